// ---- common/adcc_consts.svh ----
// Offsets, field positions, reset values and timing counts of the converter timing block
`ifndef ADCC_CONSTS_SVH
`define ADCC_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ADCC_OFS_CTRL       8'h00
`define ADCC_OFS_SYSCFG     8'h04
`define ADCC_OFS_CLKGEN     8'h08
`define ADCC_OFS_STATUS     8'h0C
`define ADCC_OFS_RESULT     8'h10
`define ADCC_OFS_IRQ_STAT   8'h14
`define ADCC_OFS_IRQ_CLR    8'h18
`define ADCC_OFS_IRQ_EN     8'h1C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ADCC_CTRL_START     0
`define ADCC_CTRL_RES8      1
`define ADCC_CTRL_POSTCAL   2
`define ADCC_CTRL_ST_LO     12
`define ADCC_CTRL_BC_LO     14
`define ADCC_IRQ_EOC        0
`define ADCC_IRQ_CAL        1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ADCC_RST_CTRL       16'h0004
`define ADCC_RST_CLKGEN     2'h0
`define ADCC_RST_IRQ_EN     2'h0

// ----------------------------------------------------------------
// Timing counts, in basic clock periods unless said otherwise
// ----------------------------------------------------------------
`define ADCC_SAMP_BC        14'h0008
`define ADCC_CONV10P_BC     14'd52
`define ADCC_CONV10_BC      14'd40
`define ADCC_CONV8P_BC      14'd44
`define ADCC_CONV8_BC       14'd32
`define ADCC_LOAD_SYS       14'd6
`define ADCC_CAL_MIN_BC     14'd484
`define ADCC_CAL_MAX_BC     14'd11696

`endif

// ---- common/adcc_pkg.sv ----
// Types shared by the converter timing block
package adcc_pkg;

	// ----------------------------------------------------------------
	// Converter sequence states
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		ST_IDLE    = 2'b00,
		ST_SAMPLE  = 2'b01,
		ST_CONVERT = 2'b10,
		ST_LOAD    = 2'b11
	} adcc_state_type;

	// Converter control settings
	typedef struct packed
	{
		logic [1:0] basic_clock_select;
		logic [1:0] sample_time_select;
		logic       postcal_en;
		logic       res8;
	} adcc_ctrl_type;

	// Clock tree settings handed to the clock generator
	typedef struct packed
	{
		logic [1:0] clock_generation_control;
		logic       cpu_clock_halving;
	} adcc_clkcfg_type;

	// System clock periods per basic clock period
	function automatic logic [4:0] adcc_div_of(input logic [1:0] sel);
		logic [4:0] r;
		case (sel)
			2'b00:   r = 5'h04;
			2'b01:   r = 5'h02;
			2'b10:   r = 5'h10;
			default: r = 5'h08;
		endcase
		return r;
	endfunction

endpackage

// ---- design/adcc_bc_div.sv ----
// Basic clock tick generator dividing the system clock
`timescale 1ns/1ps
`default_nettype none
module adcc_bc_div
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [1:0] sel,
	input  wire logic       restart,
	output var  logic       tick_q
);
	import adcc_pkg::*;

	logic [4:0] cnt_q;
	logic [4:0] cnt_d;
	logic [4:0] div;
	logic       tick_d;
	logic [4:0] gap_q;
	logic       seen_q;
	logic [1:0] sel_q;

	// ----------------------------------------------------------------
	// Divider
	// ----------------------------------------------------------------
	// Tick is flagged one count early so the user sees it at the period end
	always_comb
	begin
		div    = adcc_div_of(sel);
		tick_d = !restart && (cnt_q == div - 5'h02);
		if (restart || cnt_q >= div - 5'h01)
			cnt_d = 5'h00;
		else
			cnt_d = cnt_q + 5'h01;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt_q  <= 5'h00;
			tick_q <= 1'b0;
		end
		else
		begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Cycles since the last tick, restarted whenever the spacing is disturbed
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			gap_q  <= 5'h00;
			seen_q <= 1'b0;
			sel_q  <= 2'h0;
		end
		else
		begin
			sel_q  <= sel;
			gap_q  <= (tick_q || restart) ? 5'h00 : gap_q + 5'h01;
			seen_q <= (restart || sel != sel_q) ? 1'b0 : (seen_q || tick_q);
		end
	end

	chk_div_period: assert property (@(posedge aclk) disable iff (!aresetn)
		(tick_q && seen_q && sel == sel_q) |-> (gap_q == div - 5'h01))
		else $error("basic clock tick spacing wrong");

endmodule
`default_nettype wire

// ---- design/adcc_timing_ctrl.sv ----
// Converter timing control with AXI4-Lite register file and interrupt
// How it works
// - Basic clock is system clock over 4/2/16/8
// - Sample phase is 8/16/32/64 basic periods
// - Ten-bit: 52 or 40 periods, sample, 6
// - Eight-bit: 44 or 32 periods, sample, 6
// - Duration spans sample, determination, result load
// - Under range gives zero, over gives 3FF
// - Reset calibration lasts 484 to 11696 periods
// - Conversions during calibration stall it, flag degraded
// - CPU clock halving bit selects master or half
// - Peripheral clock follows the CPU clock
// - Clock generation register picks master source
`timescale 1ns/1ps
`default_nettype none
`include "adcc_consts.svh"
module adcc_timing_ctrl
#(
	parameter logic [13:0] CAL_MIN_BC = `ADCC_CAL_MIN_BC,
	parameter logic [13:0] CAL_MAX_BC = `ADCC_CAL_MAX_BC
)
(
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic [7:0]                awaddr,
	input  wire logic                      awvalid,
	output var  logic                      awready,
	input  wire logic [31:0]               wdata,
	input  wire logic [3:0]                wstrb,
	input  wire logic                      wvalid,
	output var  logic                      wready,
	output var  logic [1:0]                bresp,
	output var  logic                      bvalid,
	input  wire logic                      bready,
	input  wire logic [7:0]                araddr,
	input  wire logic                      arvalid,
	output var  logic                      arready,
	output var  logic [31:0]               rdata,
	output var  logic [1:0]                rresp,
	output var  logic                      rvalid,
	input  wire logic                      rready,
	input  wire logic [9:0]                ain_code,
	input  wire logic                      ain_under,
	input  wire logic                      ain_over,
	input  wire logic                      ref_noisy,
	output var  logic                      sample_phase,
	output var  logic                      irq,
	output var  adcc_pkg::adcc_clkcfg_type clk_cfg
);
	import adcc_pkg::*;

	// Control reset word, named so its fields can be sliced out
	localparam logic [15:0] RST_CTRL = `ADCC_RST_CTRL;

	// Bus group
	logic            awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
	logic            bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0]      bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0]     rdata_q, rdata_d, wdata_q, wdata_d;
	logic [7:0]      awaddr_q, awaddr_d;
	logic [3:0]      wstrb_q, wstrb_d;
	logic            aw_full_q, aw_full_d, w_full_q, w_full_d;
	adcc_ctrl_type   ctrl_q, ctrl_d;
	adcc_clkcfg_type clk_cfg_q, clk_cfg_d;
	logic [1:0]      irq_en_q, irq_en_d, irq_stat_q, irq_stat_d;
	logic            irq_q, irq_d, start_q, start_d;
	// Converter group
	adcc_state_type  state_q, state_d;
	logic [13:0]     phase_q, phase_d, cal_good_q, cal_good_d, cal_total_q, cal_total_d;
	logic [9:0]      result_q, result_d;
	logic            degraded_q, degraded_d, cal_busy_q, cal_busy_d, sample_q, sample_d;
	logic            eoc_ev, cal_ev, bc_restart, bc_tick;
	logic [13:0]     samp_len, conv_len;
	// Pin synchronisers
	logic [12:0]     pin_meta_q, pin_sync_q;
	logic [9:0]      ain_code_s;
	logic            ain_under_s, ain_over_s, ref_noisy_s;
	// Check helpers
	logic [11:0]     bcyc_q, exp_cyc;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Analog front end outputs are asynchronous to aclk
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_meta_q <= 13'h0000;
			pin_sync_q <= 13'h0000;
		end
		else
		begin
			pin_meta_q <= {ref_noisy, ain_over, ain_under, ain_code};
			pin_sync_q <= pin_meta_q;
		end
	end

	assign {ref_noisy_s, ain_over_s, ain_under_s, ain_code_s} = pin_sync_q;

	// ----------------------------------------------------------------
	// Basic clock
	// ----------------------------------------------------------------
	adcc_bc_div i_adcc_bc_div
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.sel     (ctrl_q.basic_clock_select),
		.restart (bc_restart),
		.tick_q  (bc_tick)
	);

	// ----------------------------------------------------------------
	// Register bus and interrupt
	// ----------------------------------------------------------------
	// Control register settings are frozen while a conversion is pending or running
	always_comb
	begin
		aw_full_d  = aw_full_q;
		awaddr_d   = awaddr_q;
		w_full_d   = w_full_q;
		wdata_d    = wdata_q;
		wstrb_d    = wstrb_q;
		bvalid_d   = bvalid_q;
		bresp_d    = bresp_q;
		rvalid_d   = rvalid_q;
		rdata_d    = rdata_q;
		rresp_d    = rresp_q;
		ctrl_d     = ctrl_q;
		clk_cfg_d  = clk_cfg_q;
		irq_en_d   = irq_en_q;
		irq_stat_d = irq_stat_q;
		start_d    = 1'b0;
		if (awvalid && awready_q)
		begin
			aw_full_d = 1'b1;
			awaddr_d  = awaddr;
		end
		if (wvalid && wready_q)
		begin
			w_full_d = 1'b1;
			wdata_d  = wdata;
			wstrb_d  = wstrb;
		end
		if (bvalid_q && bready)
			bvalid_d = 1'b0;
		if (aw_full_q && w_full_q && !bvalid_q)
		begin
			aw_full_d = 1'b0;
			w_full_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = 2'b00;
			case (awaddr_q)
				`ADCC_OFS_CTRL:
				begin
					if (state_q == ST_IDLE && !start_q && wstrb_q[0])
					begin
						ctrl_d.res8       = wdata_q[`ADCC_CTRL_RES8];
						ctrl_d.postcal_en = wdata_q[`ADCC_CTRL_POSTCAL];
						start_d           = wdata_q[`ADCC_CTRL_START];
					end
					if (state_q == ST_IDLE && !start_q && wstrb_q[1])
					begin
						ctrl_d.sample_time_select = wdata_q[`ADCC_CTRL_ST_LO +: 2];
						ctrl_d.basic_clock_select = wdata_q[`ADCC_CTRL_BC_LO +: 2];
					end
				end
				`ADCC_OFS_SYSCFG:
					if (wstrb_q[0])
						clk_cfg_d.cpu_clock_halving = wdata_q[0];
				`ADCC_OFS_CLKGEN:
					if (wstrb_q[0])
						clk_cfg_d.clock_generation_control = wdata_q[1:0];
				`ADCC_OFS_IRQ_EN:
					if (wstrb_q[0])
						irq_en_d = wdata_q[1:0];
				`ADCC_OFS_IRQ_CLR:
					if (wstrb_q[0])
						irq_stat_d = irq_stat_q & ~wdata_q[1:0];
				`ADCC_OFS_STATUS, `ADCC_OFS_RESULT, `ADCC_OFS_IRQ_STAT: ;
				default: bresp_d = 2'b11;
			endcase
		end
		// Events are applied after the clear so a same-cycle event survives
		irq_stat_d[`ADCC_IRQ_EOC] = irq_stat_d[`ADCC_IRQ_EOC] | eoc_ev;
		irq_stat_d[`ADCC_IRQ_CAL] = irq_stat_d[`ADCC_IRQ_CAL] | cal_ev;
		irq_d = |(irq_stat_d & irq_en_d);
		if (rvalid_q && rready)
			rvalid_d = 1'b0;
		if (arvalid && arready_q)
		begin
			rvalid_d = 1'b1;
			rresp_d  = 2'b00;
			case (araddr)
				`ADCC_OFS_CTRL:     rdata_d = {16'h0000, ctrl_q.basic_clock_select,
					ctrl_q.sample_time_select, 9'h000, ctrl_q.postcal_en, ctrl_q.res8, 1'b0};
				`ADCC_OFS_SYSCFG:   rdata_d = {31'h00000000, clk_cfg_q.cpu_clock_halving};
				`ADCC_OFS_CLKGEN:   rdata_d = {30'h00000000, clk_cfg_q.clock_generation_control};
				`ADCC_OFS_STATUS:   rdata_d = {28'h0000000, sample_q, degraded_q, cal_busy_q,
					state_q != ST_IDLE || start_q};
				`ADCC_OFS_RESULT:   rdata_d = {22'h000000, result_q};
				`ADCC_OFS_IRQ_STAT: rdata_d = {30'h00000000, irq_stat_q};
				`ADCC_OFS_IRQ_EN:   rdata_d = {30'h00000000, irq_en_q};
				`ADCC_OFS_IRQ_CLR:  rdata_d = 32'h00000000;
				default:
				begin
					rdata_d = 32'h00000000;
					rresp_d = 2'b11;
				end
			endcase
		end
		awready_d = !aw_full_d;
		wready_d  = !w_full_d;
		arready_d = !rvalid_d;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_q  <= 1'b0;
			wready_q   <= 1'b0;
			arready_q  <= 1'b0;
			bvalid_q   <= 1'b0;
			rvalid_q   <= 1'b0;
			bresp_q    <= 2'b00;
			rresp_q    <= 2'b00;
			rdata_q    <= 32'h00000000;
			aw_full_q  <= 1'b0;
			awaddr_q   <= 8'h00;
			w_full_q   <= 1'b0;
			wdata_q    <= 32'h00000000;
			wstrb_q    <= 4'h0;
			ctrl_q     <= adcc_ctrl_type'({RST_CTRL[15:12], RST_CTRL[2:1]});
			clk_cfg_q  <= adcc_clkcfg_type'({`ADCC_RST_CLKGEN, 1'b0});
			irq_en_q   <= `ADCC_RST_IRQ_EN;
			irq_stat_q <= 2'h0;
			irq_q      <= 1'b0;
			start_q    <= 1'b0;
		end
		else
		begin
			awready_q  <= awready_d;
			wready_q   <= wready_d;
			arready_q  <= arready_d;
			bvalid_q   <= bvalid_d;
			rvalid_q   <= rvalid_d;
			bresp_q    <= bresp_d;
			rresp_q    <= rresp_d;
			rdata_q    <= rdata_d;
			aw_full_q  <= aw_full_d;
			awaddr_q   <= awaddr_d;
			w_full_q   <= w_full_d;
			wdata_q    <= wdata_d;
			wstrb_q    <= wstrb_d;
			ctrl_q     <= ctrl_d;
			clk_cfg_q  <= clk_cfg_d;
			irq_en_q   <= irq_en_d;
			irq_stat_q <= irq_stat_d;
			irq_q      <= irq_d;
			start_q    <= start_d;
		end
	end

	// ----------------------------------------------------------------
	// Conversion sequence and reset calibration
	// ----------------------------------------------------------------
	// Phase lengths in basic periods; load phase counts system cycles
	always_comb
	begin
		samp_len = `ADCC_SAMP_BC << ctrl_q.sample_time_select;
		case ({ctrl_q.res8, ctrl_q.postcal_en})
			2'b01:   conv_len = `ADCC_CONV10P_BC;
			2'b00:   conv_len = `ADCC_CONV10_BC;
			2'b11:   conv_len = `ADCC_CONV8P_BC;
			default: conv_len = `ADCC_CONV8_BC;
		endcase
	end

	always_comb
	begin
		state_d     = state_q;
		phase_d     = phase_q;
		result_d    = result_q;
		degraded_d  = degraded_q;
		cal_busy_d  = cal_busy_q;
		cal_good_d  = cal_good_q;
		cal_total_d = cal_total_q;
		bc_restart  = 1'b0;
		eoc_ev      = 1'b0;
		cal_ev      = 1'b0;
		case (state_q)
			ST_IDLE:
				if (start_q)
				begin
					state_d    = ST_SAMPLE;
					phase_d    = 14'h0000;
					bc_restart = 1'b1;             // Aligns periods to the start
					degraded_d = cal_busy_q;
				end
			ST_SAMPLE:
				if (bc_tick)
				begin
					phase_d = phase_q + 14'h0001;
					if (phase_q == samp_len - 14'h0001)
					begin
						state_d = ST_CONVERT;
						phase_d = 14'h0000;
					end
				end
			ST_CONVERT:
				if (bc_tick)
				begin
					phase_d = phase_q + 14'h0001;
					if (phase_q == conv_len - 14'h0001)
					begin
						state_d = ST_LOAD;
						phase_d = 14'h0000;
					end
				end
			ST_LOAD:
			begin
				phase_d = phase_q + 14'h0001;
				if (phase_q == `ADCC_LOAD_SYS - 14'h0001)
				begin
					state_d = ST_IDLE;
					eoc_ev  = 1'b1;
					if (ain_under_s)
						result_d = 10'h000;
					else if (ain_over_s)
						result_d = 10'h3FF;
					else
						result_d = ctrl_q.res8 ? (ain_code_s & 10'h3FC) : ain_code_s;
				end
			end
			default: state_d = ST_IDLE;
		endcase
		// Calibration only advances while no conversion holds the converter
		if (cal_busy_q && state_q == ST_IDLE && bc_tick)
		begin
			cal_total_d = cal_total_q + 14'h0001;
			cal_good_d  = cal_good_q + {13'h0000, !ref_noisy_s};
			if (cal_good_d == CAL_MIN_BC || cal_total_d == CAL_MAX_BC)
			begin
				cal_busy_d = 1'b0;
				cal_ev     = 1'b1;
			end
		end
		sample_d = (state_d == ST_SAMPLE);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q     <= ST_IDLE;
			phase_q     <= 14'h0000;
			result_q    <= 10'h000;
			degraded_q  <= 1'b0;
			cal_busy_q  <= 1'b1;      // Calibration starts on reset release
			cal_good_q  <= 14'h0000;
			cal_total_q <= 14'h0000;
			sample_q    <= 1'b0;
		end
		else
		begin
			state_q     <= state_d;
			phase_q     <= phase_d;
			result_q    <= result_d;
			degraded_q  <= degraded_d;
			cal_busy_q  <= cal_busy_d;
			cal_good_q  <= cal_good_d;
			cal_total_q <= cal_total_d;
			sample_q    <= sample_d;
		end
	end

	assign awready      = awready_q;
	assign wready       = wready_q;
	assign bvalid       = bvalid_q;
	assign bresp        = bresp_q;
	assign arready      = arready_q;
	assign rvalid       = rvalid_q;
	assign rdata        = rdata_q;
	assign rresp        = rresp_q;
	assign irq          = irq_q;
	assign sample_phase = sample_q;
	assign clk_cfg      = clk_cfg_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Busy cycle count since the start was taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			bcyc_q <= 12'h000;
		else if (state_q == ST_IDLE)
			bcyc_q <= 12'h000;
		else
			bcyc_q <= bcyc_q + 12'h001;
	end

	assign exp_cyc = 12'((samp_len + conv_len) * 14'(adcc_div_of(ctrl_q.basic_clock_select))
		+ `ADCC_LOAD_SYS);

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_sample_len: assert property ((state_q == ST_SAMPLE && state_d == ST_CONVERT) |->
		(bcyc_q == 12'(samp_len * 14'(adcc_div_of(ctrl_q.basic_clock_select))) - 12'h001))
		else $error("sample phase length wrong");
	chk_conv_ten: assert property ((eoc_ev && !ctrl_q.res8) |-> bcyc_q == exp_cyc - 12'h001)
		else $error("ten-bit conversion length wrong");
	chk_conv_eight: assert property ((eoc_ev && ctrl_q.res8) |-> bcyc_q == exp_cyc - 12'h001)
		else $error("eight-bit conversion length wrong");
	chk_load_six: assert property ($rose(state_q == ST_LOAD) |->
		(state_q == ST_LOAD) [*6] ##1 (state_q == ST_IDLE))
		else $error("result load not six cycles");
	chk_clamp_low: assert property ((eoc_ev && ain_under_s) |=> result_q == 10'h000)
		else $error("under range result not zero");
	chk_clamp_high: assert property ((eoc_ev && ain_over_s && !ain_under_s) |=>
		result_q == 10'h3FF)
		else $error("over range result not full scale");
	chk_cal_bounds: assert property ($fell(cal_busy_q) |->
		(cal_total_q >= CAL_MIN_BC && cal_total_q <= CAL_MAX_BC))
		else $error("calibration length out of bounds");
	chk_cal_stall: assert property ((cal_busy_q && state_q != ST_IDLE) |=>
		$stable(cal_total_q))
		else $error("calibration advanced during conversion");
	chk_eoc_irq: assert property (eoc_ev |=> irq_stat_q[`ADCC_IRQ_EOC] ##1
		(irq == irq_en_q[`ADCC_IRQ_EOC] || irq_stat_q[`ADCC_IRQ_CAL]))
		else $error("end of conversion flag not raised");

endmodule
`default_nettype wire

// ---- verif/adcc_timing_ctrl_test.sv ----
// Self-checking bench for the converter timing block
`timescale 1ns/1ps
`default_nettype none
`include "adcc_consts.svh"
module adcc_timing_ctrl_test;
	import adcc_pkg::*;
	logic            aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic            arvalid, arready, rvalid, rready, ain_under, ain_over, ref_noisy;
	logic            sample_phase, irq;
	logic [7:0]      awaddr, araddr;
	logic [31:0]     wdata, rdata;
	logic [3:0]      wstrb;
	logic [1:0]      bresp, rresp;
	logic [9:0]      ain_code;
	adcc_clkcfg_type clk_cfg;
	int              error_cnt, checks, cyc, meas, tcnt, scnt;
	logic [33:0]     rq[$];
	logic [1:0]      bq[$];
	int              tq[$];
	int              dv[4] = '{4, 2, 16, 8};
	int              sp[4] = '{8, 16, 32, 64};

	// Short calibration bounds keep the run brief
	adcc_timing_ctrl #(.CAL_MIN_BC(14'd8), .CAL_MAX_BC(14'd40)) i_adcc_timing_ctrl
	(
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .ain_code(ain_code), .ain_under(ain_under),
		.ain_over(ain_over), .ref_noisy(ref_noisy), .sample_phase(sample_phase),
		.irq(irq), .clk_cfg(clk_cfg)
	);

	// ----------------------------------------------------------------
	// Clock, timeout and checking helpers
	// ----------------------------------------------------------------
	// Free-running 200 MHz clock
	always #2.5 aclk = ~aclk;

	// A hang ends the run as a failure
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			stop_test;
		end
	end

	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: seen %h, expected %h", $time, seen, exp);
		end
	endtask

	task stop_test;
		$display("Checks %0d, errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Bus master tasks
	// ----------------------------------------------------------------
	// Handshakes are judged at the falling edge, where every level is settled
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic ha, hw, hb;
		bq.push_back(e);
		hb = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!hb)
		begin
			@(negedge aclk);
			ha = awvalid & awready;
			hw = wvalid & wready;
			hb = bready & bvalid;
			@(posedge aclk);
			if (ha) awvalid <= 0;
			if (hw) wvalid <= 0;
			if (hb) bready <= 0;
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic ha, hb;
		rq.push_back({e, d});
		hb = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		while (!hb)
		begin
			@(negedge aclk);
			ha = arvalid & arready;
			hb = rready & rvalid;
			@(posedge aclk);
			if (ha) arvalid <= 0;
			if (hb) rready <= 0;
		end
	endtask

	task wait_irq;
		while (irq !== 1'b1)
			@(negedge aclk);
	endtask

	// One conversion; the case index picks clock, sample time, width and range
	task automatic conv(input int i);
		logic [1:0] bc, st;
		logic       r8, pc, un, ov;
		logic [9:0] code, res;
		int         cv;
		bc = 2'(i);             // Index is cut to two bits, so all four clock codes are tried
		st = 2'(3 - i);
		r8 = (i < 4) ? i[0] : 1'b0;
		pc = i[1];
		un = (i == 4);
		ov = (i == 5);
		code = 10'($urandom);
		cv = r8 ? (pc ? 44 : 32) : (pc ? 52 : 40);
		res = un ? 10'h000 : ov ? 10'h3FF : r8 ? (code & 10'h3FC) : code;
		@(posedge aclk);
		ain_code <= code;
		ain_under <= un;
		ain_over <= ov;
		tq.push_back(sp[st] * dv[bc]);
		tq.push_back((sp[st] + cv) * dv[bc] + 6);
		wr(`ADCC_OFS_CTRL, {16'h0, bc, st, 9'h0, pc, r8, 1'b1}, 2'b00);
		wait_irq;
		rd(`ADCC_OFS_RESULT, {22'h0, res}, 2'b00);
		rd(`ADCC_OFS_CTRL, {16'h0, bc, st, 9'h0, pc, r8, 1'b0}, 2'b00);
		wr(`ADCC_OFS_IRQ_CLR, 32'h1, 2'b00);
		repeat (2) @(negedge aclk);
		chk(34'(irq), 34'h0);
	endtask

	// ----------------------------------------------------------------
	// Monitors
	// ----------------------------------------------------------------
	// Bus answers and conversion timing are compared against the oldest note
	always @(negedge aclk)
	begin
		if (rvalid && rready)
			chk({rresp, rdata}, rq.pop_front());
		if (bvalid && bready)
			chk(34'(bresp), 34'(bq.pop_front()));
		if (meas != 0)
		begin
			tcnt++;
			if (sample_phase) scnt++;
			if (irq)
			begin
				meas = 0;
				chk(34'(scnt), 34'(tq.pop_front()));
				chk(34'(tcnt), 34'(tq.pop_front()));
			end
		end
		else if (sample_phase)
		begin
			meas = 1;
			tcnt = 0;
			scnt = 1;
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	// Noisy reference forces calibration to run to its upper bound
	initial
	begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 0;
		{ain_under, ain_over, awaddr, araddr, wdata, wstrb, ain_code} = 0;
		{error_cnt, checks, cyc, meas, tcnt, scnt} = 0;
		ref_noisy = 1;
		void'($urandom(90));
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		wr(`ADCC_OFS_STATUS, 32'hF, 2'b00);
		rd(`ADCC_OFS_STATUS, 32'h2, 2'b00);
		rd(`ADCC_OFS_CTRL, 32'h4, 2'b00);
		rd(`ADCC_OFS_SYSCFG, 32'h0, 2'b00);
		rd(`ADCC_OFS_CLKGEN, 32'h0, 2'b00);
		rd(`ADCC_OFS_IRQ_EN, 32'h0, 2'b00);
		rd(`ADCC_OFS_IRQ_CLR, 32'h0, 2'b00);
		rd(8'h20, 32'h0, 2'b11);
		wr(8'h24, 32'h5, 2'b11);
		wr(`ADCC_OFS_IRQ_EN, 32'h1, 2'b00);
		conv(0);
		rd(`ADCC_OFS_STATUS, 32'h6, 2'b00);
		wr(`ADCC_OFS_IRQ_EN, 32'h2, 2'b00);
		wait_irq;
		rd(`ADCC_OFS_IRQ_STAT, 32'h2, 2'b00);
		wr(`ADCC_OFS_IRQ_EN, 32'h1, 2'b00);
		repeat (2) @(negedge aclk);
		chk(34'(irq), 34'h0);
		rd(`ADCC_OFS_STATUS, 32'h4, 2'b00);
		wr(`ADCC_OFS_IRQ_CLR, 32'h3, 2'b00);
		rd(`ADCC_OFS_IRQ_STAT, 32'h0, 2'b00);
		wr(`ADCC_OFS_SYSCFG, 32'h1, 2'b00);
		wr(`ADCC_OFS_CLKGEN, 32'h2, 2'b00);
		@(negedge aclk);
		chk(34'(clk_cfg), 34'h5);
		rd(`ADCC_OFS_SYSCFG, 32'h1, 2'b00);
		rd(`ADCC_OFS_CLKGEN, 32'h2, 2'b00);
		for (int i = 0; i < 6; i++)
			conv(i);
		stop_test;
	end
endmodule
`default_nettype wire
